// [src/pmm_pkg.sv]
// shared constants and carrier types for the paged memory address map
package pmm_pkg;
  localparam int          AW         = 16;
  localparam int          GW         = 23;
  localparam logic [15:0] DF_LO      = 16'h0800;
  localparam logic [15:0] DF_HI      = 16'h0BFF;
  localparam logic [15:0] RSV_LO     = 16'h0400;
  localparam logic [15:0] RSV_HI     = 16'h13FF;
  localparam logic [15:0] PR_LO      = 16'h1000;
  localparam logic [15:0] PR_HI      = 16'h1FFF;
  localparam logic [15:0] UR_LO      = 16'h2000;
  localparam logic [15:0] UR_HI      = 16'h3FFF;
  localparam logic [15:0] PF_LO      = 16'h8000;
  localparam logic [15:0] PF_HI      = 16'hBFFF;
  localparam logic [15:0] REG_HI     = 16'h03FF;
  localparam logic [15:0] DR_LO      = 16'h0340;
  localparam int          DR_BYTES   = 20;
  localparam logic [4:0]  DF_FIX     = 5'h04;
  localparam logic [2:0]  RAM_FIX    = 3'h7;
  localparam logic [0:0]  PF_FIX     = 1'h1;
  localparam logic [6:0]  REG_FIX    = 7'h00;
  localparam logic [6:0]  UR_PG7     = 7'h7F;
  localparam logic [7:0]  UPF_LO_PG  = 8'hFD;
  localparam logic [7:0]  UPF_HI_PG  = 8'hFF;
  localparam logic [7:0]  DF_PG_RST  = 8'h00;
  localparam logic [7:0]  RAM_PG_RST = 8'hFD;
  localparam logic [7:0]  PF_PG_RST  = 8'hFE;
  localparam logic [7:0]  OFS_DFPG   = 8'h00;
  localparam logic [7:0]  OFS_RAMPG  = 8'h04;
  localparam logic [7:0]  OFS_PFPG   = 8'h08;
  localparam logic [7:0]  OFS_DISP   = 8'h0C;
  localparam logic [7:0]  OFS_STAT   = 8'h10;
  localparam logic [1:0]  RESP_OK    = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
  typedef enum logic [2:0] {
    RG_REG, RG_RSV, RG_DF, RG_DISP, RG_PRAM, RG_URAM, RG_PPF, RG_UPF
  } pmm_region_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } pmm_lreq_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    pmm_region_t region;
    logic [22:0] addr;
    logic [7:0]  wdata;
  } pmm_gbus_t;
endpackage

// [src/pmm_map.sv]
// local to global address mapper with page registers and display ram
// Function
// - 256K data flash via one 1K window
// - 0x400-0x7FF and 0xC00-0xFFF: writes dropped, reads zero
// - data flash: 5 fixed, page, 10 offset
// - paged ram: 3 fixed, page, 12 offset
// - 4K paged ram window at 0x1000
// - 8K unpaged ram at 0x2000-0x3FFF
// - 20-byte display ram usable when display off
// - decode full 64K local space from zero
// - program flash window 0x8000-0xBFFF paged
`timescale 1ns/1ps
module pmm_map (
  input  wire logic              CLOCK,     // 20 MHz
  input  wire logic              RST_N,     // sync reset
  input  wire pmm_pkg::pmm_lreq_t LREQ,     // cpu or debug request
  input  wire logic [4:0]        DISP_IDX,  // display fetch index
  output logic                   LB_RVALID, // local read answer
  output logic [7:0]             LB_RDATA,  // local read data
  output pmm_pkg::pmm_gbus_t     GBUS,      // global access
  output logic [7:0]             DISP_SEG,  // display fetch data
  input  wire logic [7:0]        AWADDR,    // axi write address
  input  wire logic              AWVALID,   // axi
  output logic                   AWREADY,   // axi
  input  wire logic [31:0]       WDATA,     // axi
  input  wire logic [3:0]        WSTRB,     // axi
  input  wire logic              WVALID,    // axi
  output logic                   WREADY,    // axi
  output logic [1:0]             BRESP,     // axi
  output logic                   BVALID,    // axi
  input  wire logic              BREADY,    // axi
  input  wire logic [7:0]        ARADDR,    // axi read address
  input  wire logic              ARVALID,   // axi
  output logic                   ARREADY,   // axi
  output logic [31:0]            RDATA,     // axi
  output logic [1:0]             RRESP,     // axi
  output logic                   RVALID,    // axi
  input  wire logic              RREADY     // axi
);
  logic [7:0]            df_page_ff, ram_page_ff, pf_page_ff;
  logic                  disp_en_ff, rsv_hit_ff;
  pmm_pkg::pmm_region_t  last_rg_ff;
  logic [7:0]            dram_ff [pmm_pkg::DR_BYTES];
  logic [7:0]            awaddr_ff;
  logic [31:0]           wdata_ff;
  logic [3:0]            wstrb_ff;
  logic                  aw_ok_ff, w_ok_ff;
  pmm_pkg::pmm_region_t  rg;
  logic [22:0]           ga;
  logic [15:0]           a;
  logic [15:0]           didx;
  logic                  do_wr, rsv_wr;

  assign a    = LREQ.addr;
  assign didx = a - pmm_pkg::DR_LO;

  // windows cut into the reserved range take precedence over it
  always_comb begin
    rg = pmm_pkg::RG_UPF;
    if (a >= pmm_pkg::DF_LO && a <= pmm_pkg::DF_HI) begin
      rg = pmm_pkg::RG_DF;
    end else if (a >= pmm_pkg::PR_LO && a <= pmm_pkg::PR_HI) begin
      rg = pmm_pkg::RG_PRAM;
    end else if (a >= pmm_pkg::RSV_LO && a <= pmm_pkg::RSV_HI) begin
      rg = pmm_pkg::RG_RSV;
    end else if (a >= pmm_pkg::DR_LO
                 && didx < 16'(pmm_pkg::DR_BYTES)) begin
      rg = pmm_pkg::RG_DISP;
    end else if (a <= pmm_pkg::REG_HI) begin
      rg = pmm_pkg::RG_REG;
    end else if (a >= pmm_pkg::UR_LO && a <= pmm_pkg::UR_HI) begin
      rg = pmm_pkg::RG_URAM;
    end else if (a >= pmm_pkg::PF_LO && a <= pmm_pkg::PF_HI) begin
      rg = pmm_pkg::RG_PPF;
    end
  end

  always_comb begin
    case (rg)
      pmm_pkg::RG_DF:   ga = {pmm_pkg::DF_FIX, df_page_ff, a[9:0]};
      pmm_pkg::RG_PRAM: ga = {pmm_pkg::RAM_FIX, ram_page_ff, a[11:0]};
      pmm_pkg::RG_URAM: ga = {pmm_pkg::RAM_FIX, pmm_pkg::UR_PG7, a[12:0]};
      pmm_pkg::RG_PPF:  ga = {pmm_pkg::PF_FIX, pf_page_ff, a[13:0]};
      pmm_pkg::RG_UPF:  ga = {pmm_pkg::PF_FIX,
                              a[15] ? pmm_pkg::UPF_HI_PG : pmm_pkg::UPF_LO_PG,
                              a[13:0]};
      default:          ga = {pmm_pkg::REG_FIX, a};
    endcase
  end

  assign rsv_wr = LREQ.valid && LREQ.write && rg == pmm_pkg::RG_RSV;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      GBUS <= '0;
    end else begin
      GBUS.valid  <= LREQ.valid && rg != pmm_pkg::RG_RSV
                     && rg != pmm_pkg::RG_DISP;
      GBUS.write  <= LREQ.write;
      GBUS.region <= rg;
      GBUS.addr   <= ga;
      GBUS.wdata  <= LREQ.wdata;
    end
  end

  // display ram: cpu side always open; fetch port only while enabled
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      LB_RVALID <= 1'b0;
      LB_RDATA  <= 8'h00;
    end else begin
      LB_RVALID <= LREQ.valid && !LREQ.write
                   && (rg == pmm_pkg::RG_RSV || rg == pmm_pkg::RG_DISP);
      LB_RDATA  <= 8'h00;
      if (LREQ.valid && !LREQ.write && rg == pmm_pkg::RG_DISP) begin
        LB_RDATA <= dram_ff[didx[4:0]];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      for (int i = 0; i < pmm_pkg::DR_BYTES; i++) begin
        dram_ff[i] <= 8'h00;
      end
    end else if (LREQ.valid && LREQ.write && rg == pmm_pkg::RG_DISP) begin
      dram_ff[didx[4:0]] <= LREQ.wdata;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      DISP_SEG <= 8'h00;
    end else begin
      DISP_SEG <= (disp_en_ff && DISP_IDX < 5'(pmm_pkg::DR_BYTES))
                  ? dram_ff[DISP_IDX] : 8'h00;
    end
  end

  // axi write: address and data taken in either order, answered together
  assign do_wr = aw_ok_ff && w_ok_ff && !BVALID;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      aw_ok_ff  <= 1'b0;
      w_ok_ff   <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      AWREADY   <= 1'b0;
      WREADY    <= 1'b0;
      BVALID    <= 1'b0;
      BRESP     <= pmm_pkg::RESP_OK;
    end else begin
      AWREADY <= !aw_ok_ff && !(AWVALID && AWREADY);
      WREADY  <= !w_ok_ff && !(WVALID && WREADY);
      if (AWVALID && AWREADY) begin
        aw_ok_ff  <= 1'b1;
        awaddr_ff <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_ok_ff  <= 1'b1;
        wdata_ff <= WDATA;
        wstrb_ff <= WSTRB;
      end
      if (do_wr) begin
        BVALID <= 1'b1;
        BRESP  <= (awaddr_ff <= pmm_pkg::OFS_STAT && awaddr_ff[1:0] == 2'h0)
                  ? pmm_pkg::RESP_OK : pmm_pkg::RESP_SLV;
      end else if (BVALID && BREADY) begin
        BVALID   <= 1'b0;
        aw_ok_ff <= 1'b0;
        w_ok_ff  <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      df_page_ff  <= pmm_pkg::DF_PG_RST;
      ram_page_ff <= pmm_pkg::RAM_PG_RST;
      pf_page_ff  <= pmm_pkg::PF_PG_RST;
      disp_en_ff  <= 1'b0;
    end else if (do_wr && wstrb_ff[0]) begin
      if (awaddr_ff == pmm_pkg::OFS_DFPG) begin
        df_page_ff <= wdata_ff[7:0];
      end else if (awaddr_ff == pmm_pkg::OFS_RAMPG) begin
        ram_page_ff <= wdata_ff[7:0];
      end else if (awaddr_ff == pmm_pkg::OFS_PFPG) begin
        pf_page_ff <= wdata_ff[7:0];
      end else if (awaddr_ff == pmm_pkg::OFS_DISP) begin
        disp_en_ff <= wdata_ff[0];
      end
    end
  end

  // sticky dropped-write flag: a new drop beats a clear in the same cycle
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rsv_hit_ff <= 1'b0;
      last_rg_ff <= pmm_pkg::RG_REG;
    end else begin
      if (rsv_wr) begin
        rsv_hit_ff <= 1'b1;
      end else if (do_wr && wstrb_ff[0] && awaddr_ff == pmm_pkg::OFS_STAT
                   && wdata_ff[0]) begin
        rsv_hit_ff <= 1'b0;
      end
      if (LREQ.valid) begin
        last_rg_ff <= rg;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= pmm_pkg::RESP_OK;
    end else begin
      ARREADY <= !RVALID && !(ARVALID && ARREADY);
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RRESP  <= pmm_pkg::RESP_OK;
        RDATA  <= 32'h0000_0000;
        if (ARADDR == pmm_pkg::OFS_DFPG) begin
          RDATA[7:0] <= df_page_ff;
        end else if (ARADDR == pmm_pkg::OFS_RAMPG) begin
          RDATA[7:0] <= ram_page_ff;
        end else if (ARADDR == pmm_pkg::OFS_PFPG) begin
          RDATA[7:0] <= pf_page_ff;
        end else if (ARADDR == pmm_pkg::OFS_DISP) begin
          RDATA[0] <= disp_en_ff;
        end else if (ARADDR == pmm_pkg::OFS_STAT) begin
          RDATA[3:0] <= {last_rg_ff, rsv_hit_ff};
        end else begin
          RRESP <= pmm_pkg::RESP_SLV;
        end
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  property p_df_addr;
    @(posedge CLOCK) disable iff (!RST_N)
    LREQ.valid && rg == pmm_pkg::RG_DF |=> GBUS.valid
      && GBUS.addr == {pmm_pkg::DF_FIX, $past(df_page_ff),
                       $past(LREQ.addr[9:0])};
  endproperty
  a_df_addr: assert property (p_df_addr)
    else $error("data flash global address wrong");

  property p_pram_addr;
    @(posedge CLOCK) disable iff (!RST_N)
    LREQ.valid && a[15:12] == 4'h1 |=> GBUS.region == pmm_pkg::RG_PRAM
      && GBUS.addr[19:12] == $past(ram_page_ff)
      && GBUS.addr[22:20] == pmm_pkg::RAM_FIX;
  endproperty
  a_pram_addr: assert property (p_pram_addr)
    else $error("paged ram global address wrong");

  property p_rsv_wr;
    @(posedge CLOCK) disable iff (!RST_N)
    rsv_wr |=> !GBUS.valid && !LB_RVALID && rsv_hit_ff;
  endproperty
  a_rsv_wr: assert property (p_rsv_wr)
    else $error("reserved write not dropped");

  property p_rsv_rd;
    @(posedge CLOCK) disable iff (!RST_N)
    LREQ.valid && !LREQ.write && rg == pmm_pkg::RG_RSV
      |=> LB_RVALID && LB_RDATA == 8'h00;
  endproperty
  a_rsv_rd: assert property (p_rsv_rd)
    else $error("reserved read not zero");

  property p_uram;
    @(posedge CLOCK) disable iff (!RST_N)
    LREQ.valid && a[15:13] == 3'h1 |=> GBUS.region == pmm_pkg::RG_URAM
      && GBUS.addr[19:13] == pmm_pkg::UR_PG7;
  endproperty
  a_uram: assert property (p_uram)
    else $error("unpaged ram depends on page");

  property p_ppf;
    @(posedge CLOCK) disable iff (!RST_N)
    LREQ.valid && a[15:14] == 2'h2 |=>
      GBUS.addr == {pmm_pkg::PF_FIX, $past(pf_page_ff), $past(a[13:0])};
  endproperty
  a_ppf: assert property (p_ppf)
    else $error("program flash window address wrong");

  // write, one idle cycle, then a read of the same byte returns the data
  property p_dram;
    @(posedge CLOCK) disable iff (!RST_N)
    LREQ.valid && LREQ.write && rg == pmm_pkg::RG_DISP ##1 !LREQ.valid
      ##1 LREQ.valid && !LREQ.write && LREQ.addr == $past(LREQ.addr, 2)
      |=> LB_RVALID && LB_RDATA == $past(LREQ.wdata, 3);
  endproperty
  a_dram: assert property (p_dram)
    else $error("display ram read-back mismatch");

  property p_page_wr;
    @(posedge CLOCK) disable iff (!RST_N)
    do_wr && wstrb_ff[0] && awaddr_ff == pmm_pkg::OFS_RAMPG
      |=> BVALID && ram_page_ff == $past(wdata_ff[7:0]);
  endproperty
  a_page_wr: assert property (p_page_wr)
    else $error("page register write lost");

  property p_answered;
    @(posedge CLOCK) disable iff (!RST_N)
    LREQ.valid |=> GBUS.valid || LB_RVALID || $past(rsv_wr)
      || ($past(LREQ.write) && $past(rg) == pmm_pkg::RG_DISP);
  endproperty
  a_answered: assert property (p_answered)
    else $error("local access not decoded");
endmodule

// [bench/pmm_cpu_model.sv]
// cpu-side partner that issues local byte requests to the mapper
`timescale 1ns/1ps
module pmm_cpu_model (
  input  wire logic               clk,    // system clock
  output pmm_pkg::pmm_lreq_t      lreq,   // request to mapper
  input  wire pmm_pkg::pmm_gbus_t gbus,   // global access seen
  input  wire logic               rvalid, // local answer
  input  wire logic [7:0]         rdata   // local answer data
);
  initial lreq = '0;
  // one access; the answer stands for one cycle after the taking edge,
  // so it is sampled just after that edge and not one edge later
  task automatic access(input logic w, input logic [15:0] a,
    input logic [7:0] d, output pmm_pkg::pmm_gbus_t g,
    output logic v, output logic [7:0] r);
    @(posedge clk);
    lreq <= {1'b1, w, a, d};
    @(posedge clk);
    // released lines carry inverted junk so stale values cannot pass
    lreq <= {1'b0, ~w, ~a, ~d};
    #1;
    g = gbus;
    v = rvalid;
    r = rdata;
  endtask
endmodule

// [bench/tb_paged_memory_address_map.sv]
// self-checking bench for the paged memory address map
`timescale 1ns/1ps
module tb_paged_memory_address_map;
  logic               clock, rst_n, awvalid, wvalid, bready;
  logic               arvalid, rready, awready, wready, bvalid;
  logic               arready, rvalid, lb_rvalid, v;
  logic [7:0]         awaddr, araddr, lb_rdata, disp_seg, r8;
  logic [4:0]         disp_idx;
  logic [31:0]        wdata, rdata, d;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp, rs;
  pmm_pkg::pmm_lreq_t lreq;
  pmm_pkg::pmm_gbus_t gbus, g;
  int                 fail_count, tests_run;
  pmm_map uut (.CLOCK(clock), .RST_N(rst_n), .LREQ(lreq),
    .DISP_IDX(disp_idx), .LB_RVALID(lb_rvalid), .LB_RDATA(lb_rdata),
    .GBUS(gbus), .DISP_SEG(disp_seg), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready));
  pmm_cpu_model cpu (.clk(clock), .lreq(lreq), .gbus(gbus),
    .rvalid(lb_rvalid), .rdata(lb_rdata));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bus(input pmm_pkg::pmm_region_t rg,
    input logic [22:0] a);
    chk({g.valid, g.region, 5'h00, g.addr}, {1'b1, rg, 5'h00, a});
  endtask
  // waits as long as the slave needs; only the watchdog ends a hang
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dd);
    @(posedge clock);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= dd;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic test_done;
    $display("tests %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    fail_count++;
    test_done;
  end
  initial begin
    rst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; wstrb = 4'hF; disp_idx = 5'h05;
    fail_count = 0; tests_run = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    axi_rd(8'h00);
    chk(d, {24'h0, pmm_pkg::DF_PG_RST});
    chk({30'h0, rs}, {30'h0, pmm_pkg::RESP_OK});
    axi_rd(8'h04);
    chk(d, {24'h0, pmm_pkg::RAM_PG_RST});
    axi_rd(8'h08);
    chk(d, {24'h0, pmm_pkg::PF_PG_RST});
    axi_rd(8'h14);
    chk({30'h0, rs}, {30'h0, pmm_pkg::RESP_SLV});
    axi_wr(8'h02, 32'h0000_0001);
    chk({30'h0, rs}, {30'h0, pmm_pkg::RESP_SLV});
    axi_wr(8'h00, 32'h0000_0005);
    chk({30'h0, rs}, {30'h0, pmm_pkg::RESP_OK});
    axi_rd(8'h00);
    chk(d, 32'h0000_0005);
    axi_wr(8'h04, 32'h0000_0012);
    axi_rd(8'h04);
    chk(d, 32'h0000_0012);
    $display("test registers done");
    cpu.access(1'b0, 16'h0010, 8'h00, g, v, r8);
    chk_bus(pmm_pkg::RG_REG, {7'h00, 16'h0010});
    cpu.access(1'b0, 16'h0900, 8'h00, g, v, r8);
    chk_bus(pmm_pkg::RG_DF, {pmm_pkg::DF_FIX, 8'h05, 10'h100});
    cpu.access(1'b0, 16'h0BFF, 8'h00, g, v, r8);
    chk_bus(pmm_pkg::RG_DF, {pmm_pkg::DF_FIX, 8'h05, 10'h3FF});
    cpu.access(1'b0, 16'h1ABC, 8'h00, g, v, r8);
    chk_bus(pmm_pkg::RG_PRAM, {pmm_pkg::RAM_FIX, 8'h12, 12'hABC});
    cpu.access(1'b0, 16'h1000, 8'h00, g, v, r8);
    chk_bus(pmm_pkg::RG_PRAM, {pmm_pkg::RAM_FIX, 8'h12, 12'h0});
    cpu.access(1'b1, 16'h2345, 8'h3C, g, v, r8);
    chk_bus(pmm_pkg::RG_URAM, {3'h7, 7'h7F, 13'h0345});
    chk({23'h0, g.write, g.wdata}, {23'h0, 1'b1, 8'h3C});
    cpu.access(1'b0, 16'h9234, 8'h00, g, v, r8);
    chk_bus(pmm_pkg::RG_PPF, {1'b1, 8'hFE, 14'h1234});
    cpu.access(1'b0, 16'hC123, 8'h00, g, v, r8);
    chk_bus(pmm_pkg::RG_UPF, {1'b1, 8'hFF, 14'h0123});
    $display("test mapping done");
    cpu.access(1'b0, 16'h0500, 8'h00, g, v, r8);
    chk({22'h0, g.valid, v, r8}, {22'h0, 1'b0, 1'b1, 8'h00});
    cpu.access(1'b1, 16'h0C10, 8'h77, g, v, r8);
    chk({30'h0, g.valid, v}, 32'h0000_0000);
    // status: last region in bits 3:1, sticky drop flag in bit 0
    axi_rd(8'h10);
    chk(d, {28'h0, pmm_pkg::RG_RSV, 1'b1});
    axi_wr(8'h10, 32'h0000_0001);
    axi_rd(8'h10);
    chk(d & 32'h0000_0001, 32'h0000_0000);
    $display("test reserved done");
    cpu.access(1'b1, 16'h0345, 8'hA5, g, v, r8);
    cpu.access(1'b0, 16'h0345, 8'h00, g, v, r8);
    chk({23'h0, v, r8}, {23'h0, 1'b1, 8'hA5});
    chk({24'h0, disp_seg}, 32'h0000_0000);
    axi_wr(8'h0C, 32'h0000_0001);
    repeat (2) @(posedge clock);
    #1;
    chk({24'h0, disp_seg}, 32'h0000_00A5);
    $display("test display done");
    test_done;
  end
endmodule
